/* rtl/ciid_regs.sv */
// Purpose: processor interface and component id register bank
// Assumes: classic wishbone slave, one clock, synchronous reset
// Notes:   pending id and priority come from arbitration logic on core_clk
//          ack is registered, raised at the edge that takes the request
//          writes commit on the edge that raises ack
//          binary point is banked by the security of the request
//          id bytes sit at 0xff0..0xffc, upper bits read zero
//          unlisted offsets read zero and drop writes
`timescale 1ns/1ps
`default_nettype none
`include "ciid_defs.svh"

module ciid_regs #(
    // identity values are arbitrary, override per product
    parameter logic [31:0] SIGNATURE = 32'h5a6c_3e91, // arbitrary value
    parameter int          PART_NUM  = 'h123,         // arbitrary value
    parameter int          ARCH_VER  = 'h1,           // arbitrary value
    parameter int          REVISION  = 'h0,           // arbitrary value
    parameter int          JEP_CONT  = 'h2,           // arbitrary value
    parameter int          JEP_CODE  = 'h15           // arbitrary value
) (
    // clock and synchronous active-low reset
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,

    // wishbone slave
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [`CIID_ADR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    output var  logic [31:0]              wb_dat_o,
    output var  logic                     wb_ack_o,

    // security attribute of the current access
    input  wire logic                     secure_access,

    // from arbitration logic
    input  wire logic                     pend_valid,
    input  wire logic [`CIID_ID_W-1:0]    pend_id,
    input  wire logic [`CIID_PRIO_W-1:0]  pend_prio,

    // to the rest of the controller
    output var  logic [31:0]              iface_control,
    output var  logic [`CIID_PMASK_W-1:0] priority_mask,
    output var  logic [`CIID_BPR_W-1:0]   binary_point_s,
    output var  logic [`CIID_BPR_W-1:0]   binary_point_ns,
    output var  logic [`CIID_PRIO_W-1:0]  running_priority,
    output var  logic                     irq_ack_pulse,
    output var  logic [`CIID_ID_W-1:0]    irq_ack_id,
    output var  logic                     eoi_pulse,
    output var  logic [`CIID_ID_W-1:0]    eoi_id
);

    // ======================================================================
    // parameter checks
    // each ident field must fit its slot of the ident word
    // part number fills bits 31..20
    if (PART_NUM < 0 || PART_NUM > 'hfff) begin : g_chk_part
        $error("part number does not fit 12 bits");
    end

    // architecture version fills bits 19..16
    if (ARCH_VER < 0 || ARCH_VER > 'hf) begin : g_chk_arch
        $error("architecture version does not fit 4 bits");
    end

    // revision fills bits 15..12
    if (REVISION < 0 || REVISION > 'hf) begin : g_chk_rev
        $error("revision does not fit 4 bits");
    end

    // continuation code fills bits 11..8
    if (JEP_CONT < 0 || JEP_CONT > 'hf) begin : g_chk_cont
        $error("continuation code does not fit 4 bits");
    end

    // manufacturer code fills bits 6..0
    if (JEP_CODE < 0 || JEP_CODE > 'h7f) begin : g_chk_code
        $error("manufacturer code does not fit 7 bits");
    end

    // ======================================================================
    // constant implementer ident word
    // layout: part, architecture, revision, implementer
    // folded to a constant: no flop and no write path
    // bit 7 of the implementer field is always zero
    localparam logic [31:0] IMPL_WORD =
        (32'(PART_NUM) << `CIID_IMPL_PART_LSB)
      | (32'(ARCH_VER) << `CIID_IMPL_ARCH_LSB)
      | (32'(REVISION) << `CIID_IMPL_REV_LSB)
      | (32'(JEP_CONT) << `CIID_IMPL_CONT_LSB)
      | {24'h00_0000, 1'b0, 7'(JEP_CODE)};

    // ======================================================================
    // signature bytes, one hard-wired register each
    // byte i lands in signature bits 8*i+7..8*i
    logic [7:0] sig_byte [4];

    for (genvar i = 0; i < 4; i++) begin : g_sig
        // one instance per byte, value cut from the signature
        ciid_sig_byte #(
            .VALUE (SIGNATURE[8*i +: 8])
        ) u_sig (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .byte_q   (sig_byte[i])
        );
    end

    // ======================================================================
    // state record
    // every flop of the bank except the signature bytes sits in this one record
    // st_d is rebuilt each cycle by the next-state process
    ciid_pkg::ciid_state_t st_q;
    ciid_pkg::ciid_state_t st_d;

    // ======================================================================
    // byte-enable merge of a write into an old value
    // lanes with sel low keep the old value
    // narrow fields are widened before and cut after
    function automatic logic [31:0] ciid_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  sel
    );
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    // ======================================================================
    // bus timing
    // edge 1: request taken, ack and read data registered, write done
    // edge 2: master sees ack; ack falls as it masks the request
    // edge 3: a request still held would be taken again
    // read data holds until the next request is answered
    // pulses towards the controller rise at edge 1 with ack

    // ======================================================================
    // request decode
    // ack masks the request, so rd_en and wr_en last one cycle
    // address bits 1:0 are ignored, every register is a word
    // request qualifiers
    logic                   req_new;
    logic                   wr_en;
    logic                   rd_en;
    logic [`CIID_ADR_W-1:0] word_adr;
    // scratch and widened copies for the merge
    logic [31:0]            merged;
    logic [31:0]            bpr_s_w;
    logic [31:0]            bpr_ns_w;
    logic [31:0]            pmask_w;

    // new request is answered one cycle after it appears
    assign req_new  = wb_cyc_i & wb_stb_i & ~st_q.ack;
    assign wr_en    = req_new & wb_we_i;
    assign rd_en    = req_new & ~wb_we_i;
    assign word_adr = {wb_adr_i[`CIID_ADR_W-1:2], 2'b00};

    // widened copies of narrow fields for byte merges
    // upper bits of narrow fields read as zero
    assign pmask_w  = {{(32-`CIID_PMASK_W){1'b0}}, st_q.pmask};
    assign bpr_s_w  = {{(32-`CIID_BPR_W){1'b0}}, st_q.bpr_s};
    assign bpr_ns_w = {{(32-`CIID_BPR_W){1'b0}}, st_q.bpr_ns};

    // ======================================================================
    // security banking of the binary point
    // secure requests to 0x008 reach the secure copy, others the other
    // secure requests to 0x01c reach the non-secure copy as an alias
    // non-secure requests to 0x01c read zero and drop writes
    // the priority logic sees both copies on separate ports

    // ======================================================================
    // read mux
    // word offered to the bus this cycle
    logic [31:0] rd_word;
    logic [`CIID_ID_W-1:0] hp_id;

    // spurious id stands in while nothing is pending
    // acknowledge and highest pending share this id
    assign hp_id = pend_valid ? pend_id : `CIID_SPURIOUS_ID;

    // read data follows the address every cycle
    // it is captured only when a read is taken
    always_comb begin
        rd_word = 32'h0000_0000;

        if (word_adr == `CIID_OFF_CTRL) begin
            rd_word = st_q.ctrl;
        end else if (word_adr == `CIID_OFF_PMASK) begin
            rd_word = pmask_w;
        end else if (word_adr == `CIID_OFF_BPR) begin
            rd_word = secure_access ? bpr_s_w : bpr_ns_w;
        end else if (word_adr == `CIID_OFF_IACK) begin
            // spurious id while nothing is pending
            rd_word = {{(32-`CIID_ID_W){1'b0}}, hp_id};
        end else if (word_adr == `CIID_OFF_EOI) begin
            // write-only register reads zero
            rd_word = 32'h0000_0000;
        end else if (word_adr == `CIID_OFF_RPR) begin
            // set by acknowledge, idled by end of interrupt
            rd_word = {{(32-`CIID_PRIO_W){1'b0}}, st_q.rpr};
        end else if (word_adr == `CIID_OFF_HPEND) begin
            rd_word = {{(32-`CIID_ID_W){1'b0}}, hp_id};
        end else if (word_adr == `CIID_OFF_ABPR) begin
            if (secure_access) begin
                rd_word = bpr_ns_w;
            end
        end else if (word_adr == `CIID_OFF_IMPL) begin
            // constant word built above
            rd_word = IMPL_WORD;
        end else if (word_adr == `CIID_OFF_SIG0) begin
            // id bytes: low byte only, upper bits zero
            rd_word = {24'h00_0000, sig_byte[0]};
        end else if (word_adr == `CIID_OFF_SIG1) begin
            rd_word = {24'h00_0000, sig_byte[1]};
        end else if (word_adr == `CIID_OFF_SIG2) begin
            rd_word = {24'h00_0000, sig_byte[2]};
        end else if (word_adr == `CIID_OFF_SIG3) begin
            rd_word = {24'h00_0000, sig_byte[3]};
        end
    end

    // ======================================================================
    // next state
    // defaults hold every field, set ack to req_new and drop both strobes
    // read data is cleared on writes so no stale word follows
    always_comb begin
        st_d         = st_q;
        st_d.ack     = req_new;
        st_d.ack_stb = 1'b0;
        st_d.eoi_stb = 1'b0;
        merged       = 32'h0000_0000;
        // reads capture the word, writes answer zero
        if (rd_en) begin
            st_d.dat = rd_word;
        end else if (req_new) begin
            st_d.dat = 32'h0000_0000;
        end

        // reading acknowledge with a pending id activates it
        // the id's priority becomes the running priority
        if (rd_en && word_adr == `CIID_OFF_IACK && pend_valid) begin
            st_d.rpr     = pend_prio;
            st_d.ack_stb = 1'b1;
            st_d.ack_id  = pend_id;
        end

        // writes commit on the edge that raises ack
        if (wr_en) begin
            if (word_adr == `CIID_OFF_CTRL) begin
                // every selected byte lands
                st_d.ctrl = ciid_merge(st_q.ctrl, wb_dat_i, wb_sel_i);
            end else if (word_adr == `CIID_OFF_PMASK) begin
                // only the low byte is kept
                merged = ciid_merge(pmask_w, wb_dat_i, wb_sel_i);
                st_d.pmask = merged[`CIID_PMASK_W-1:0];
            end else if (word_adr == `CIID_OFF_BPR) begin
                // the request's security picks the copy
                if (secure_access) begin
                    merged = ciid_merge(bpr_s_w, wb_dat_i, wb_sel_i);
                    st_d.bpr_s = merged[`CIID_BPR_W-1:0];
                end else begin
                    merged = ciid_merge(bpr_ns_w, wb_dat_i, wb_sel_i);
                    st_d.bpr_ns = merged[`CIID_BPR_W-1:0];
                end
            end else if (word_adr == `CIID_OFF_EOI) begin
                // pulse the id out and idle the running priority
                merged = ciid_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
                st_d.eoi_stb = 1'b1;
                st_d.eoi_id  = merged[`CIID_ID_W-1:0];
                st_d.rpr     = `CIID_IDLE_PRIO;
            end else if (word_adr == `CIID_OFF_ABPR) begin
                // alias is writable by secure requests only
                if (secure_access) begin
                    merged = ciid_merge(bpr_ns_w, wb_dat_i, wb_sel_i);
                    st_d.bpr_ns = merged[`CIID_BPR_W-1:0];
                end
            end
            // read-only, id and unlisted offsets drop the write
        end
    end

    // ======================================================================
    // state register
    // synchronous reset loads constants only
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            // bus answer and captured read data
            st_q.ack     <= 1'b0;
            st_q.dat     <= 32'h0000_0000;
            // software visible registers
            st_q.ctrl    <= `CIID_RST_CTRL;
            st_q.pmask   <= `CIID_RST_PMASK;
            st_q.bpr_s   <= `CIID_RST_BPR_S;
            st_q.bpr_ns  <= `CIID_RST_BPR_NS;
            st_q.rpr     <= `CIID_IDLE_PRIO;
            // strobes low, ids zero
            st_q.ack_stb <= 1'b0;
            st_q.ack_id  <= `CIID_RST_ID;
            st_q.eoi_stb <= 1'b0;
            st_q.eoi_id  <= `CIID_RST_ID;
        end else begin
            st_q <= st_d;
        end
    end

    // ======================================================================
    // outputs straight from the state record
    // no logic between a flop and a port
    // pulses last one cycle, ids hold between them
    // control, mask and binary points feed the priority logic
    assign wb_ack_o         = st_q.ack;
    assign wb_dat_o         = st_q.dat;
    assign iface_control    = st_q.ctrl;
    assign priority_mask    = st_q.pmask;
    assign binary_point_s   = st_q.bpr_s;
    assign binary_point_ns  = st_q.bpr_ns;
    assign running_priority = st_q.rpr;
    assign irq_ack_pulse    = st_q.ack_stb;
    assign irq_ack_id       = st_q.ack_id;
    assign eoi_pulse        = st_q.eoi_stb;
    assign eoi_id           = st_q.eoi_id;

endmodule

`default_nettype wire

/* rtl/ciid_defs.svh */
// Purpose: offsets, reset values and field positions of the id bank
// Assumes: byte addresses inside one 4 KB processor interface region
// Notes:   definitions only, included by bare name
`ifndef CIID_DEFS_SVH
`define CIID_DEFS_SVH

// ==========================================================================
// register byte offsets
`define CIID_ADR_W          12
`define CIID_OFF_CTRL       12'h000
`define CIID_OFF_PMASK      12'h004
`define CIID_OFF_BPR        12'h008
`define CIID_OFF_IACK       12'h00c
`define CIID_OFF_EOI        12'h010
`define CIID_OFF_RPR        12'h014
`define CIID_OFF_HPEND      12'h018
`define CIID_OFF_ABPR       12'h01c
`define CIID_OFF_IMPL       12'h0fc
`define CIID_OFF_SIG0       12'hff0
`define CIID_OFF_SIG1       12'hff4
`define CIID_OFF_SIG2       12'hff8
`define CIID_OFF_SIG3       12'hffc

// ==========================================================================
// field widths
`define CIID_PMASK_W        8
`define CIID_BPR_W          3
`define CIID_ID_W           10
`define CIID_PRIO_W         8

// ==========================================================================
// reset values
`define CIID_RST_CTRL       32'h0000_0000
`define CIID_RST_PMASK      8'h00
`define CIID_RST_BPR_S      3'h2
`define CIID_RST_BPR_NS     3'h3
`define CIID_SPURIOUS_ID    10'h3ff
`define CIID_IDLE_PRIO      8'hff
`define CIID_RST_ID         10'h000

// ==========================================================================
// implementer ident field positions
`define CIID_IMPL_PART_LSB  20
`define CIID_IMPL_ARCH_LSB  16
`define CIID_IMPL_REV_LSB   12
`define CIID_IMPL_CONT_LSB  8

`endif

/* rtl/ciid_pkg.sv */
// Purpose: types of the processor interface id bank
// Assumes: ciid_defs.svh on the include path
// Notes:   the state record is registered as one word in the top module
`include "ciid_defs.svh"

package ciid_pkg;

    // ======================================================================
    // state of the register bank, except the signature bytes
    typedef struct packed {
        logic                        ack;
        logic [31:0]                 dat;
        logic [31:0]                 ctrl;
        logic [`CIID_PMASK_W-1:0]    pmask;
        logic [`CIID_BPR_W-1:0]      bpr_s;
        logic [`CIID_BPR_W-1:0]      bpr_ns;
        logic [`CIID_PRIO_W-1:0]     rpr;
        logic                        ack_stb;
        logic [`CIID_ID_W-1:0]       ack_id;
        logic                        eoi_stb;
        logic [`CIID_ID_W-1:0]       eoi_id;
    } ciid_state_t;

endpackage

/* rtl/ciid_sig_byte.sv */
// Purpose: one hard-wired byte of the component signature
// Assumes: VALUE fixed at elaboration
// Notes:   holds its reset value for ever, no write path exists
`timescale 1ns/1ps
`default_nettype none

module ciid_sig_byte #(
    parameter logic [7:0] VALUE = 8'h00
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    output var  logic [7:0] byte_q
);

    // ======================================================================
    // constant register, reloads its own value on every edge
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            byte_q <= VALUE;
        end else begin
            byte_q <= VALUE;
        end
    end

endmodule

`default_nettype wire

/* dv/ciid_regs_properties.sv */
// Purpose: bus and register properties of the id bank
// Assumes: classic wishbone slave, one clock, synchronous reset
// Notes:   bound into ciid_regs after the module
`timescale 1ns/1ps
`default_nettype none
`include "ciid_defs.svh"

module ciid_regs_properties #(
    parameter logic [31:0] SIGNATURE = 32'h5a6c_3e91
) (
    input wire logic                     core_clk,
    input wire logic                     rst_n,
    input wire logic                     wb_cyc_i,
    input wire logic                     wb_stb_i,
    input wire logic                     wb_we_i,
    input wire logic [`CIID_ADR_W-1:0]   wb_adr_i,
    input wire logic [3:0]               wb_sel_i,
    input wire logic [31:0]              wb_dat_i,
    input wire logic [31:0]              wb_dat_o,
    input wire logic                     wb_ack_o,
    input wire logic                     secure_access,
    input wire logic                     pend_valid,
    input wire logic [`CIID_PRIO_W-1:0]  pend_prio,
    input wire logic [31:0]              iface_control,
    input wire logic [`CIID_PMASK_W-1:0] priority_mask,
    input wire logic [`CIID_BPR_W-1:0]   binary_point_ns,
    input wire logic [`CIID_PRIO_W-1:0]  running_priority,
    input wire logic                     irq_ack_pulse,
    input wire logic                     eoi_pulse
);
    // ======================================================================
    // request taken at this edge
    logic                                rq;
    logic                                rd;
    logic                                wr;
    assign rq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd = rq && !wb_we_i;
    assign wr = rq && wb_we_i;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // ======================================================================
    // bus answer and register effects
    a_ack_one_shot: assert property (rq |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse after request");
    a_no_stray_ack: assert property (!rq |=> !wb_ack_o)
        else $error("ack without a taken request");
    a_reset_values: assert property ($rose(rst_n) |-> iface_control == 32'h0
        && priority_mask == 8'h00 && running_priority == 8'hff)
        else $error("wrong value after reset");
    a_ctrl_write: assert property (wr && wb_adr_i == `CIID_OFF_CTRL
        && wb_sel_i == 4'hf |=> iface_control == $past(wb_dat_i))
        else $error("control write lost");
    a_ctrl_hold: assert property (!(wr
        && {wb_adr_i[`CIID_ADR_W-1:2], 2'b00} == `CIID_OFF_CTRL)
        |=> $stable(iface_control))
        else $error("control changed without write");
    a_mask_write: assert property (wr && wb_adr_i == `CIID_OFF_PMASK
        && wb_sel_i[0] |=> priority_mask == $past(wb_dat_i[7:0]))
        else $error("mask write lost");
    a_idle_ack_id: assert property (rd && wb_adr_i == `CIID_OFF_IACK
        && !pend_valid |=> wb_dat_o == 32'h0000_03ff)
        else $error("idle acknowledge id wrong");
    a_ack_running: assert property (rd && wb_adr_i == `CIID_OFF_IACK
        && pend_valid |=> irq_ack_pulse
        && running_priority == $past(pend_prio))
        else $error("acknowledge did not raise running priority");
    a_eoi_pulse: assert property (wr && wb_adr_i == `CIID_OFF_EOI |=> eoi_pulse
        && running_priority == 8'hff ##1 !eoi_pulse)
        else $error("end of interrupt handling wrong");
    a_sig_low: assert property (rd && wb_adr_i == `CIID_OFF_SIG0
        |=> wb_dat_o == {24'h0, SIGNATURE[7:0]})
        else $error("signature byte 0 wrong");
    a_impl_bit7: assert property (rd && wb_adr_i == `CIID_OFF_IMPL
        |=> !wb_dat_o[7])
        else $error("implementer bit 7 set");
    a_alias_gate: assert property (wr && wb_adr_i == `CIID_OFF_ABPR
        && !secure_access |=> $stable(binary_point_ns))
        else $error("alias written without secure access");
endmodule

bind ciid_regs ciid_regs_properties #(.SIGNATURE(SIGNATURE)) u_props (
    .core_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .secure_access,
    .pend_valid, .pend_prio, .iface_control, .priority_mask,
    .binary_point_ns, .running_priority, .irq_ack_pulse, .eoi_pulse
);
`default_nettype wire

/* dv/ciid_regs_tb.sv */
// Purpose: self-checking bench of the id register bank
// Assumes: classic wishbone master tasks, fixed random seed
// Notes:   ident parameters below are arbitrary values
`timescale 1ns/1ps
`default_nettype none

module ciid_regs_tb;
    localparam logic [31:0] SIG = 32'hc3a5_1e67; // arbitrary value
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic        sec = 1'b1;
    logic        pv = 1'b0;
    logic [11:0] adr = 12'h0;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] q, d, ctrl, dout, ictl;
    logic [9:0]  pid = 10'h0;
    logic [9:0]  aid, eid;
    logic [7:0]  ppr = 8'h0;
    logic [7:0]  pm, rp, mask;
    logic [2:0]  bs, bn;
    logic        ack, pa, pe, p_ack, p_eoi;
    int          miscompares = 0;
    int          checks = 0;
    int          cycles = 0;

    ciid_regs #(.SIGNATURE(SIG), .PART_NUM('h2a7), .ARCH_VER(2),
        .REVISION(1), .JEP_CONT(4), .JEP_CODE('h3c)) DUT (
        .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dout), .wb_ack_o(ack), .secure_access(sec),
        .pend_valid(pv), .pend_id(pid), .pend_prio(ppr),
        .iface_control(ictl), .priority_mask(pm), .binary_point_s(bs),
        .binary_point_ns(bn), .running_priority(rp),
        .irq_ack_pulse(pa), .irq_ack_id(aid), .eoi_pulse(pe), .eoi_id(eid));

    // ======================================================================
    // clock and hang guard
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (miscompares == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    // one classic cycle; outputs taken at the ack edge
    task automatic bus(input logic w, s, input logic [11:0] a,
                       input logic [31:0] v, input logic [3:0] m);
        @(posedge core_clk);
        {cyc, stb, we, sec} <= {2'b11, w, s};
        adr <= a;
        dat <= v;
        sel <= m;
        do begin
            @(posedge core_clk);
        end while (ack !== 1'b1);
        q = dout;
        p_ack = pa;
        p_eoi = pe;
        {cyc, stb} <= 2'b00;
    endtask

    function automatic logic [31:0] merge(logic [31:0] o, n, logic [3:0] m);
        for (int i = 0; i < 4; i++)
            if (m[i])
                o[8*i +: 8] = n[8*i +: 8];
        return o;
    endfunction

    // ======================================================================
    // main sequence
    initial begin
        logic [11:0] ofs [8] = '{12'h000, 12'h004, 12'h008, 12'h00c,
                                 12'h014, 12'h018, 12'h01c, 12'h010};
        logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h2, 32'h3ff,
                                32'hff, 32'h3ff, 32'h3, 32'h0};
        void'($urandom(32'h6817));
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            bus(0, 1, ofs[i], 0, 0);
            chk("reset value", rv[i], q);
        end
        bus(0, 0, 12'h008, 0, 0);
        chk("bpr nonsecure", 32'h3, q);
        bus(0, 0, 12'h01c, 0, 0);
        chk("alias nonsecure", 32'h0, q);
        for (int i = 0; i < 4; i++) begin
            bus(0, 1, 12'hff0 + 12'(4 * i), 0, 0);
            chk("signature", {24'h0, SIG[8*i +: 8]}, q);
            bus(1, 1, 12'hff0 + 12'(4 * i), $urandom, 4'hf);
            bus(0, 1, 12'hff0 + 12'(4 * i), 0, 0);
            chk("signature kept", {24'h0, SIG[8*i +: 8]}, q);
        end
        bus(0, 1, 12'h0fc, 0, 0);
        chk("ident", {12'h2a7, 4'h2, 4'h1, 4'h4, 1'b0, 7'h3c}, q);
        ctrl = 0;
        mask = 0;
        repeat (12) begin
            d = $urandom;
            bus(1, 1, 12'h000, d, 4'($urandom));
            ctrl = merge(ctrl, d, sel);
            chk("control out", ctrl, ictl);
            bus(1, 1, 12'h004, d, 4'($urandom));
            if (sel[0])
                mask = d[7:0];
            chk("mask out", {24'h0, mask}, {24'h0, pm});
            bus(0, 1, 12'h004, 0, 0);
            chk("mask", {24'h0, mask}, q);
            bus(0, 1, 12'h000, 0, 0);
            chk("control", ctrl, q);
        end
        bus(1, 1, 12'h008, 32'h5, 4'hf);
        bus(1, 1, 12'h01c, 32'h6, 4'hf);
        bus(1, 0, 12'h01c, 32'h1, 4'hf);
        bus(0, 1, 12'h008, 0, 0);
        chk("bpr secure", 32'h5, q);
        bus(0, 0, 12'h008, 0, 0);
        chk("bpr alias", 32'h6, q);
        chk("bp outputs", {26'h0, 3'h5, 3'h6}, {26'h0, bs, bn});
        @(posedge core_clk);
        pv <= 1'b1;
        pid <= 10'($urandom);
        ppr <= 8'($urandom);
        bus(0, 1, 12'h018, 0, 0);
        chk("highest pending", {22'h0, pid}, q);
        bus(0, 1, 12'h00c, 0, 0);
        chk("ack id", {22'h0, pid}, q);
        chk("ack pulse", 32'h1, {31'h0, p_ack});
        chk("ack id out", {22'h0, pid}, {22'h0, aid});
        chk("running", {24'h0, ppr}, {24'h0, rp});
        d = $urandom;
        bus(1, 1, 12'h010, d, 4'hf);
        chk("eoi pulse", 32'h1, {31'h0, p_eoi});
        chk("eoi id", {22'h0, d[9:0]}, {22'h0, eid});
        chk("running idle", 32'hff, {24'h0, rp});
        bus(0, 1, 12'h010, 0, 0);
        chk("eoi read", 32'h0, q);
        pv <= 1'b0;
        bus(1, 1, 12'h014, 32'h12, 4'hf);
        bus(0, 1, 12'h014, 0, 0);
        chk("running ro", 32'hff, q);
        repeat (6) begin
            d = 32'h020 + 32'(($urandom % 55) * 4);
            bus(1, 1, d[11:0], $urandom, 4'hf);
            bus(0, 1, d[11:0], 0, 0);
            chk("unlisted", 32'h0, q);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
